// ---- rtl/daad_datapath.sv ----
// Purpose: Single-cycle add, magnitude and scaled address datapath
// Assumes: Operands arrive from the core register file on clk
// Notes:   Writeback port is registered; file writes on wbValid
//
// Our own choices: the register offsets and the APB interface to the registers.
`include "daad_cfg.svh"

// What this block does
// RULE_01 - 32-bit magnitude; minimum negative saturates to largest positive.
// RULE_02 - 40-bit magnitude; minimum negative saturates to largest positive.
// RULE_03 - Decode plain signed sums: 32, 32to40, 32+40 on L; 32 on S.
// RULE_04 - Sign-extended 5-bit constant first operand, 32 or 40-bit sum.
// RULE_05 - Address unit sum: register first, register or unsigned 5-bit second.
// RULE_06 - Long values are 40-bit, high bits in upper register of pair.
// RULE_07 - Destination written only when condition is true.
// RULE_08 - Sources read and result written in first execute cycle.
// RULE_09 - Byte-scaled address sum, register or unsigned 5-bit offset.
// RULE_10 - Circular only for A4-A7/B4-B7 with mode enabled; else linear.
// RULE_11 - Halfword-scaled sum shifts offset left by one.
// RULE_12 - Word-scaled sum shifts offset left by two.
// RULE_13 - Add signed 16-bit immediate to destination, write same register.
// RULE_14 - Unsigned widening sums give 40-bit unsigned result.
// RULE_15 - Linear address sums scale offset by 2, 1 or 0 bits.
// RULE_16 - Circular mode changes only bits N..0; upper bits keep base.
// RULE_17 - Block size counted in bytes whatever the access size.
// RULE_18 - Cross-path operand read from opposite file when cross bit set.
// RULE_19 - Plain sums wrap at destination width, carry discarded.
// RULE_20 - Upper register of pair gets sign or zero extended high byte.
module daad_datapath
    import daad_pkg::*;
(
    input  wire logic        clk,         // Core clock
    input  wire logic        rst,         // Sync reset
    input  wire logic        issueIn,     // Instruction in E1
    input  wire logic        condIn,      // Condition result
    input  wire daad_unit_t  unitIn,      // Functional unit
    input  wire logic [6:0]  opfieldIn,   // Opfield
    input  wire logic        crossIn,     // Cross-path bit
    input  wire logic        constSelIn,  // D unit constant offset
    input  wire logic [4:0]  constIn,     // 5-bit constant field
    input  wire logic [15:0] const16In,   // signed_const16
    input  wire logic [31:0] plainIn,     // Non-cross operand
    input  wire logic [7:0]  longHighIn,  // Long operand high
    input  wire logic [31:0] xSameIn,     // Cross operand, own file
    input  wire logic [31:0] xCrossIn,    // Cross operand, far file
    input  wire logic [31:0] dstCurIn,    // Destination contents
    input  wire logic [4:0]  dstIdxIn,    // Destination index
    input  wire logic        dstFileBIn,  // Destination in B file
    input  wire logic [4:0]  baseIdxIn,   // Base register index
    input  wire logic        baseFileBIn, // Base in B file
    output logic             wbValid,     // Write low register
    output logic             wbHiValid,   // Write upper register
    output logic [4:0]       wbIdx,       // Written index
    output logic             wbFileB,     // Written file
    output logic [31:0]      wbLo,        // Low word
    output logic [31:0]      wbHi,        // Upper register
    input  wire logic        psel,        // APB select
    input  wire logic        penable,     // APB enable
    input  wire logic        pwrite,      // APB write
    input  wire logic [11:0] paddr,       // APB address
    input  wire logic [31:0] pwdata,      // APB write data
    output logic [31:0]      prdata,      // APB read data
    output logic             pready,      // APB ready
    output logic             pslverr      // APB error
);
    logic [31:0] mode_reg;
    logic [15:0] wrCnt_reg;
    logic [15:0] nopCnt_reg;
    logic [31:0] xOp;
    logic [39:0] longOp;
    logic [39:0] c5s;
    logic [39:0] res;
    logic        legal;
    logic        isLong;
    logic        isSigned;
    logic        circ;
    logic [1:0]  sh;
    logic [4:0]  blkN;
    logic [32:0] maskWide;
    logic [31:0] mask;
    logic [31:0] offs;
    logic [31:0] aSum;
    logic [31:0] k16Ext;
    logic        fire;
    logic        apbHit;

    assign xOp = crossIn ? xCrossIn : xSameIn; // see RULE_18
    assign longOp = {longHighIn, plainIn}; // see RULE_06
    assign c5s = {{35{constIn[4]}}, constIn};
    assign k16Ext = {{16{const16In[15]}}, const16In};
    assign blkN = mode_reg[`DAAD_BLK_MSB:`DAAD_BLK_LSB];
    // Block of 2^(N+1) bytes, unscaled
    assign maskWide = (33'h0_0000_0001 << ({1'b0, blkN} + 6'h01)) - 33'h0_0000_0001; // see RULE_17
    assign mask = maskWide[31:0];
    assign circ = (baseIdxIn[4:2] == `DAAD_CIRC_GRP)
                  && mode_reg[{baseFileBIn, baseIdxIn[1:0]}]; // see RULE_10
    assign offs = constSelIn ? {27'h000_0000, constIn} : xSameIn;
    // Size code sits in opfield bits 3:2
    assign sh = opfieldIn[3:2]; // see RULE_09, RULE_11, RULE_12
    assign aSum = plainIn + (offs << sh); // see RULE_15

    always_comb begin
        res = 40'h00_0000_0000;
        legal = 1'b1;
        isLong = 1'b0;
        isSigned = 1'b1;
        unique case (unitIn)
            DAAD_UNIT_L: begin
                unique case (opfieldIn)
                    `DAAD_OP_ABS32: begin
                        if (xOp == `DAAD_MIN32) begin
                            res = {8'h00, `DAAD_MAX32}; // see RULE_01
                        end else begin
                            res = {8'h00, xOp[31] ? -xOp : xOp};
                        end
                    end
                    `DAAD_OP_ABS40: begin
                        isLong = 1'b1;
                        if (longOp == `DAAD_MIN40) begin
                            res = `DAAD_MAX40; // see RULE_02
                        end else begin
                            res = longOp[39] ? -longOp : longOp;
                        end
                    end
                    `DAAD_OP_ADD32: res = {8'h00, plainIn + xOp}; // see RULE_03
                    `DAAD_OP_ADD3240: begin
                        isLong = 1'b1;
                        res = {{8{plainIn[31]}}, plainIn} + {{8{xOp[31]}}, xOp}; // see RULE_03
                    end
                    `DAAD_OP_ADDXL: begin
                        isLong = 1'b1;
                        res = {{8{xOp[31]}}, xOp} + longOp; // see RULE_19
                    end
                    `DAAD_OP_ADDC32: res = {8'h00, c5s[31:0] + xOp}; // see RULE_04
                    `DAAD_OP_ADDCL: begin
                        isLong = 1'b1;
                        res = c5s + longOp; // see RULE_04
                    end
                    `DAAD_OP_UADD: begin
                        isLong = 1'b1;
                        isSigned = 1'b0;
                        res = {8'h00, plainIn} + {8'h00, xOp}; // see RULE_14
                    end
                    `DAAD_OP_UADDL: begin
                        isLong = 1'b1;
                        isSigned = 1'b0;
                        res = {8'h00, xOp} + longOp; // see RULE_14
                    end
                    default: legal = 1'b0;
                endcase
            end
            DAAD_UNIT_S: begin
                unique case (opfieldIn[5:0])
                    `DAAD_OP_SADD: res = {8'h00, plainIn + xOp}; // see RULE_03
                    `DAAD_OP_SADDC: res = {8'h00, c5s[31:0] + xOp};
                    default: legal = 1'b0;
                endcase
            end
            DAAD_UNIT_D: begin
                unique case (opfieldIn[5:0])
                    `DAAD_OP_DADD: res = {8'h00, plainIn + xSameIn}; // see RULE_05
                    `DAAD_OP_DADDC: res = {8'h00, plainIn + {27'h000_0000, constIn}};
                    `DAAD_OP_BSUM, `DAAD_OP_BSUMC,
                    `DAAD_OP_HSUM, `DAAD_OP_HSUMC,
                    `DAAD_OP_WSUM, `DAAD_OP_WSUMC: begin
                        if (circ) begin
                            res = {8'h00, (plainIn & ~mask) | (aSum & mask)}; // see RULE_16
                        end else begin
                            res = {8'h00, aSum};
                        end
                    end
                    default: legal = 1'b0;
                endcase
            end
            DAAD_UNIT_K: res = {8'h00, dstCurIn + k16Ext}; // see RULE_13
        endcase
    end

    assign fire = issueIn && condIn && legal;

    always_ff @(posedge clk) begin
        if (rst) begin
            wbValid <= 1'b0;
            wbHiValid <= 1'b0;
        end else begin
            wbValid <= fire; // see RULE_07, RULE_08
            wbHiValid <= fire && isLong;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wbIdx <= 5'h00;
            wbFileB <= 1'b0;
            wbLo <= 32'h0000_0000;
            wbHi <= 32'h0000_0000;
        end else if (fire) begin
            wbIdx <= dstIdxIn;
            wbFileB <= dstFileBIn;
            wbLo <= res[31:0];
            wbHi <= {{24{isSigned & res[39]}}, res[39:32]}; // see RULE_20
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrCnt_reg <= 16'h0000;
            nopCnt_reg <= 16'h0000;
        end else if (issueIn) begin
            if (fire) begin
                wrCnt_reg <= wrCnt_reg + 16'h0001;
            end else begin
                nopCnt_reg <= nopCnt_reg + 16'h0001;
            end
        end
    end

    // APB: one wait state, write at the ready edge
    assign apbHit = (paddr == `DAAD_OFF_MODE) || (paddr == `DAAD_OFF_STAT);

    always_ff @(posedge clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= !apbHit;
            if (!pwrite && paddr == `DAAD_OFF_MODE) begin
                prdata <= mode_reg;
            end else if (!pwrite && paddr == `DAAD_OFF_STAT) begin
                prdata <= {nopCnt_reg, wrCnt_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg <= `DAAD_MODE_RST;
        end else if (psel && penable && pready && pwrite && paddr == `DAAD_OFF_MODE) begin
            mode_reg <= '0;
            mode_reg[`DAAD_CIRC_MSB:`DAAD_CIRC_LSB] <= pwdata[`DAAD_CIRC_MSB:`DAAD_CIRC_LSB];
            mode_reg[`DAAD_BLK_MSB:`DAAD_BLK_LSB] <= pwdata[`DAAD_BLK_MSB:`DAAD_BLK_LSB];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    cond_nop_a: assert property (issueIn && !condIn |=> !wbValid) // see RULE_07
        else $error("Write despite false condition");
    one_cycle_a: assert property (fire |=> wbValid && wbIdx == $past(dstIdxIn)) // see RULE_08
        else $error("Result not written next cycle");
    abs32_sat_a: assert property (fire && unitIn == DAAD_UNIT_L && opfieldIn == `DAAD_OP_ABS32 // see RULE_01
                                  && xOp == `DAAD_MIN32 |=> wbLo == `DAAD_MAX32 && !wbHiValid)
        else $error("32-bit magnitude not saturated");
    abs40_sat_a: assert property (fire && unitIn == DAAD_UNIT_L && opfieldIn == `DAAD_OP_ABS40 // see RULE_02
                                  && longOp == `DAAD_MIN40 |=> wbHiValid && {wbHi[7:0], wbLo} == `DAAD_MAX40)
        else $error("40-bit magnitude not saturated");
    hi_ext_a: assert property (wbHiValid |-> wbHi[31:8] == {24{wbHi[7]}} || wbHi[31:8] == 24'h00_0000) // see RULE_20
        else $error("Upper register not extended");
    circ_keep_a: assert property (fire && unitIn == DAAD_UNIT_D && opfieldIn[5] && circ // see RULE_16
                                  |=> (wbLo & ~$past(mask)) == ($past(plainIn) & ~$past(mask)))
        else $error("Circular sum changed upper bits");
    word_lin_a: assert property (fire && unitIn == DAAD_UNIT_D && opfieldIn[5:0] == `DAAD_OP_WSUM // see RULE_15
                                 && !circ |=> wbLo == $past(plainIn) + ($past(xSameIn) << 2))
        else $error("Linear word sum wrong");
    accum_k_a: assert property (fire && unitIn == DAAD_UNIT_K // see RULE_13
                                |=> wbLo == $past(dstCurIn) + $past(k16Ext) && wbIdx == $past(dstIdxIn))
        else $error("Constant accumulate wrong");
    abs_neg_a: assert property (fire && unitIn == DAAD_UNIT_L && opfieldIn == `DAAD_OP_ABS32 // see RULE_01
                                && xOp[31] && xOp != `DAAD_MIN32 |=> wbLo == 32'h0000_0000 - $past(xOp))
        else $error("32-bit magnitude of negative wrong");
    add_wrap_a: assert property (fire && unitIn == DAAD_UNIT_L && opfieldIn == `DAAD_OP_ADD32 // see RULE_19
                                 |=> wbLo == $past(plainIn) + $past(xOp) && !wbHiValid)
        else $error("Plain 32-bit sum wrong");
    uadd_zero_a: assert property (fire && unitIn == DAAD_UNIT_L // see RULE_14
                                  && (opfieldIn == `DAAD_OP_UADD || opfieldIn == `DAAD_OP_UADDL)
                                  |=> wbHiValid && wbHi[31:8] == 24'h00_0000)
        else $error("Unsigned sum upper bits not zero");
    long_sext_a: assert property (fire && isLong && isSigned // see RULE_20
                                  |=> wbHiValid && wbHi[31:8] == {24{wbHi[7]}})
        else $error("Signed long upper bits not extended");
    cross_sel_a: assert property (fire && unitIn == DAAD_UNIT_S && opfieldIn[5:0] == `DAAD_OP_SADD // see RULE_18
                                  |=> wbLo == $past(plainIn) + ($past(crossIn) ? $past(xCrossIn) : $past(xSameIn)))
        else $error("Cross operand from wrong file");
    addr_linear_a: assert property (fire && unitIn == DAAD_UNIT_D && opfieldIn[5] // see RULE_10
                                    && baseIdxIn[4:2] != `DAAD_CIRC_GRP && !constSelIn
                                    |=> wbLo == $past(plainIn) + ($past(xSameIn) << $past(opfieldIn[3:2])))
        else $error("Linear address sum wrong");
    dadd_order_a: assert property (fire && unitIn == DAAD_UNIT_D && opfieldIn[5:0] == `DAAD_OP_DADDC // see RULE_05
                                   |=> wbLo == $past(plainIn) + {27'h000_0000, $past(constIn)})
        else $error("Address unit constant sum wrong");
    half_circ_a: assert property (fire && unitIn == DAAD_UNIT_D && opfieldIn[5:0] == `DAAD_OP_HSUM // see RULE_11
                                  && circ && !constSelIn |=> (wbLo & $past(mask))
                                  == (($past(plainIn) + ($past(xSameIn) << 1)) & $past(mask)))
        else $error("Circular halfword sum wrong");
    refuse_nop_a: assert property (issueIn && !legal |=> !wbValid) // see RULE_07
        else $error("Write for illegal opfield");
    apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
        else $error("APB ready not one cycle");

endmodule // daad_datapath

// ---- rtl/daad_cfg.svh ----
// Purpose: Opfield codes, register offsets and constants
// Assumes: Included by the datapath and its package users
// Notes:   Definitions only
`ifndef DAAD_CFG_SVH
`define DAAD_CFG_SVH
`define DAAD_OP_ABS32   7'h1A
`define DAAD_OP_ABS40   7'h38
`define DAAD_OP_ADD32   7'h03
`define DAAD_OP_ADD3240 7'h23
`define DAAD_OP_ADDXL   7'h21
`define DAAD_OP_ADDC32  7'h02
`define DAAD_OP_ADDCL   7'h20
`define DAAD_OP_UADD    7'h2B
`define DAAD_OP_UADDL   7'h29
`define DAAD_OP_SADD    6'h07
`define DAAD_OP_SADDC   6'h06
`define DAAD_OP_DADD    6'h10
`define DAAD_OP_DADDC   6'h12
`define DAAD_OP_BSUM    6'h30
`define DAAD_OP_BSUMC   6'h32
`define DAAD_OP_HSUM    6'h34
`define DAAD_OP_HSUMC   6'h36
`define DAAD_OP_WSUM    6'h38
`define DAAD_OP_WSUMC   6'h3A
`define DAAD_MAX32      32'h7FFF_FFFF
`define DAAD_MIN32      32'h8000_0000
`define DAAD_MAX40      40'h7F_FFFF_FFFF
`define DAAD_MIN40      40'h80_0000_0000
`define DAAD_CIRC_GRP   3'h1
`define DAAD_SH_BYTE    2'h0
`define DAAD_SH_HALF    2'h1
`define DAAD_SH_WORD    2'h2
`define DAAD_OFF_MODE   12'h000
`define DAAD_OFF_STAT   12'h004
`define DAAD_CIRC_LSB   0
`define DAAD_CIRC_MSB   7
`define DAAD_BLK_LSB    16
`define DAAD_BLK_MSB    20
`define DAAD_MODE_RST   32'h0000_0000
`endif

// ---- rtl/daad_pkg.sv ----
// Purpose: Types of the add and magnitude datapath
// Assumes: Nothing
// Notes:   Unit selects which opfield table applies
package daad_pkg;
    typedef enum logic [1:0] {
        DAAD_UNIT_L,
        DAAD_UNIT_S,
        DAAD_UNIT_D,
        DAAD_UNIT_K
    } daad_unit_t;
endpackage

// ---- verif/daad_core_model.sv ----
// Purpose: Core register file as seen from the writeback port
// Assumes: A write lands at the edge that ends the writeback cycle
// Notes:   Upper word of a pair goes to the next index
module daad_core_model (
    input wire logic        clk,       // Core clock
    input wire logic        wbValid,   // Low word write
    input wire logic        wbHiValid, // Upper word write
    input wire logic [4:0]  wbIdx,     // Written index
    input wire logic        wbFileB,   // Written file
    input wire logic [31:0] wbLo,      // Low word
    input wire logic [31:0] wbHi       // Upper word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] rf [0:63];
    always @(posedge clk) begin
        if (wbValid) rf[{wbFileB, wbIdx}] <= wbLo;
        if (wbHiValid) rf[{wbFileB, wbIdx + 5'd1}] <= wbHi;
    end
endmodule // daad_core_model

// ---- verif/test_dsp_add_abs_datapath.sv ----
// Purpose: Self-checking bench of the add and magnitude datapath
// Assumes: Writeback one cycle after issue; APB slave answers after exactly one wait state
// Notes:   Each scenario task drives and judges its own results
`include "daad_cfg.svh"
module test_dsp_add_abs_datapath import daad_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, issueIn = 0, condIn = 0, crossIn = 0, constSelIn = 0;
    logic        dstFileBIn = 0, baseFileBIn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        wbValid, wbHiValid, wbFileB, pready, pslverr;
    logic [4:0]  constIn = '0, dstIdxIn = '0, baseIdxIn = '0, wbIdx;
    logic [6:0]  opfieldIn = '0;
    logic [7:0]  longHighIn = '0;
    logic [11:0] paddr = '0;
    logic [15:0] const16In = '0;
    logic [31:0] plainIn = '0, xSameIn = '0, xCrossIn = '0, dstCurIn = '0, pwdata = '0;
    logic [31:0] wbLo, wbHi, prdata;
    daad_unit_t  unitIn = DAAD_UNIT_L;
    int          numErrors = 0, nChecks = 0;
    always #25 clk = ~clk;
    daad_datapath daad_datapath_inst (.clk(clk), .rst(rst), .issueIn(issueIn), .condIn(condIn), .unitIn(unitIn),
        .opfieldIn(opfieldIn), .crossIn(crossIn), .constSelIn(constSelIn), .constIn(constIn), .const16In(const16In),
        .plainIn(plainIn), .longHighIn(longHighIn), .xSameIn(xSameIn), .xCrossIn(xCrossIn), .dstCurIn(dstCurIn),
        .dstIdxIn(dstIdxIn), .dstFileBIn(dstFileBIn), .baseIdxIn(baseIdxIn), .baseFileBIn(baseFileBIn),
        .wbValid(wbValid), .wbHiValid(wbHiValid), .wbIdx(wbIdx), .wbFileB(wbFileB), .wbLo(wbLo), .wbHi(wbHi),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    daad_core_model daad_core_model_inst (.clk(clk), .wbValid(wbValid), .wbHiValid(wbHiValid), .wbIdx(wbIdx),
        .wbFileB(wbFileB), .wbLo(wbLo), .wbHi(wbHi));
    task automatic check(input string name, input logic [39:0] got, input logic [39:0] exp);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic go(input daad_unit_t u, input logic [6:0] op, input logic c, input logic [31:0] pl,
                      input logic [31:0] xs);
        @(posedge clk);
        unitIn <= u;
        opfieldIn <= op;
        condIn <= c;
        plainIn <= pl;
        xSameIn <= xs;
        issueIn <= 1'b1;
    endtask
    task automatic expect_wb(input logic v, input logic hv, input logic [31:0] lo, input logic [31:0] hi);
        @(posedge clk);
        issueIn <= 1'b0;
        #1;
        check("wbValid", 40'(wbValid), 40'(v));
        check("wbHiValid", 40'(wbHiValid), 40'(hv));
        if (v) check("wbLo", 40'(wbLo), 40'(lo));
        if (hv) check("wbHi", 40'(wbHi), 40'(hi));
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                       output logic err);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        check("apbWait", 40'(n), 40'h00_0000_0002);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic t_magnitude;
        go(DAAD_UNIT_L, `DAAD_OP_ABS32, 1'b1, '0, `DAAD_MIN32);
        expect_wb(1'b1, 1'b0, `DAAD_MAX32, '0);
        go(DAAD_UNIT_L, `DAAD_OP_ABS32, 1'b1, '0, 32'hFFFF_FFFB);
        expect_wb(1'b1, 1'b0, 32'h0000_0005, '0);
        go(DAAD_UNIT_L, `DAAD_OP_ABS40, 1'b1, '0, '0);
        longHighIn <= 8'h80;
        expect_wb(1'b1, 1'b1, 32'hFFFF_FFFF, 32'h0000_007F);
        go(DAAD_UNIT_L, `DAAD_OP_ABS40, 1'b1, 32'hFFFF_FFFD, '0);
        longHighIn <= 8'hFF;
        expect_wb(1'b1, 1'b1, 32'h0000_0003, '0);
    endtask
    task automatic t_sums;
        go(DAAD_UNIT_L, `DAAD_OP_ADD32, 1'b1, 32'h7FFF_FFFF, 32'h0000_0001);
        expect_wb(1'b1, 1'b0, 32'h8000_0000, '0);
        go(DAAD_UNIT_L, `DAAD_OP_ADD3240, 1'b1, 32'h8000_0000, 32'h8000_0000);
        expect_wb(1'b1, 1'b1, '0, 32'hFFFF_FFFF);
        go(DAAD_UNIT_L, `DAAD_OP_ADDXL, 1'b1, 32'hFFFF_FF12, 32'h0000_325A);
        expect_wb(1'b1, 1'b1, 32'h0000_316C, '0);
        go(DAAD_UNIT_S, 7'(`DAAD_OP_SADD), 1'b1, 32'h0000_0005, 32'hFFFF_FFFE);
        expect_wb(1'b1, 1'b0, 32'h0000_0003, '0);
        go(DAAD_UNIT_S, 7'(`DAAD_OP_SADD), 1'b1, 32'h0000_0005, 32'h0000_0999);
        crossIn <= 1'b1;
        xCrossIn <= 32'h0000_0010;
        expect_wb(1'b1, 1'b0, 32'h0000_0015, '0);
    endtask
    task automatic t_consts;
        go(DAAD_UNIT_L, `DAAD_OP_ADDC32, 1'b1, '0, 32'h0000_325A);
        constIn <= 5'h13;
        crossIn <= 1'b0;
        expect_wb(1'b1, 1'b0, 32'h0000_324D, '0);
        go(DAAD_UNIT_L, `DAAD_OP_ADDCL, 1'b1, '0, '0);
        constIn <= 5'h1F;
        longHighIn <= 8'h00;
        expect_wb(1'b1, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        go(DAAD_UNIT_S, 7'(`DAAD_OP_SADDC), 1'b1, '0, 32'h0000_0001);
        constIn <= 5'h0F;
        expect_wb(1'b1, 1'b0, 32'h0000_0010, '0);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_DADD), 1'b1, 32'h0000_325A, 32'h0000_001A);
        expect_wb(1'b1, 1'b0, 32'h0000_3274, '0);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_DADDC), 1'b1, 32'h0000_325A, 32'hFFFF_FFFF);
        constSelIn <= 1'b1;
        constIn <= 5'h1A;
        expect_wb(1'b1, 1'b0, 32'h0000_3274, '0);
    endtask
    task automatic t_accum_unsigned;
        go(DAAD_UNIT_K, 7'h00, 1'b1, '0, '0);
        const16In <= 16'h3C29;
        dstCurIn <= 32'h0021_37E1;
        expect_wb(1'b1, 1'b0, 32'h0021_740A, '0);
        go(DAAD_UNIT_K, 7'h00, 1'b1, '0, '0);
        const16In <= 16'h8000;
        dstCurIn <= 32'h0000_0001;
        expect_wb(1'b1, 1'b0, 32'hFFFF_8001, '0);
        go(DAAD_UNIT_L, `DAAD_OP_UADD, 1'b1, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        expect_wb(1'b1, 1'b1, 32'hFFFF_FFFE, 32'h0000_0001);
        go(DAAD_UNIT_L, `DAAD_OP_UADDL, 1'b1, 32'hFFFF_FF12, 32'h0000_325A);
        longHighIn <= 8'hFF;
        expect_wb(1'b1, 1'b1, 32'h0000_316C, '0);
    endtask
    task automatic t_refused;
        go(DAAD_UNIT_L, `DAAD_OP_ADD32, 1'b1, 32'h0000_0001, 32'h0000_0002);
        dstIdxIn <= 5'd3;
        dstFileBIn <= 1'b1;
        expect_wb(1'b1, 1'b0, 32'h0000_0003, '0);
        go(DAAD_UNIT_L, `DAAD_OP_ADD32, 1'b0, 32'h0000_0005, 32'h0000_0005);
        expect_wb(1'b0, 1'b0, '0, '0);
        go(DAAD_UNIT_L, 7'h7F, 1'b1, 32'h0000_0005, 32'h0000_0005);
        expect_wb(1'b0, 1'b0, '0, '0);
        check("regFile", 40'(daad_core_model_inst.rf[35]), 40'h00_0000_0003);
    endtask
    task automatic t_address;
        logic [31:0] rd;
        logic        err;
        apb(1'b1, `DAAD_OFF_MODE, 32'h0002_0001, rd, err);
        apb(1'b0, `DAAD_OFF_MODE, '0, rd, err);
        check("modeReg", 40'(rd), 40'h00_0002_0001);
        apb(1'b0, 12'h008, '0, rd, err);
        check("slvErr", 40'(err), 40'h00_0000_0001);
        apb(1'b0, `DAAD_OFF_STAT, '0, rd, err);
        check("statReg", 40'(rd), 40'h00_0002_0013);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_HSUM), 1'b1, 32'h0000_0100, 32'h0000_000B);
        constSelIn <= 1'b0;
        baseIdxIn <= 5'd4;
        expect_wb(1'b1, 1'b0, 32'h0000_0106, '0);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_BSUM), 1'b1, 32'h0000_0100, 32'h0000_000B);
        expect_wb(1'b1, 1'b0, 32'h0000_0103, '0);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_WSUMC), 1'b1, 32'h0002_0000, 32'hFFFF_FFFF);
        constSelIn <= 1'b1;
        constIn <= 5'h02;
        expect_wb(1'b1, 1'b0, 32'h0002_0000, '0);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_WSUM), 1'b1, 32'h0002_0000, 32'h0000_0002);
        constSelIn <= 1'b0;
        baseIdxIn <= 5'd8;
        expect_wb(1'b1, 1'b0, 32'h0002_0008, '0);
        go(DAAD_UNIT_D, 7'(`DAAD_OP_HSUM), 1'b1, 32'h0000_0100, 32'h0000_000B);
        baseIdxIn <= 5'd4;
        baseFileBIn <= 1'b1;
        expect_wb(1'b1, 1'b0, 32'h0000_0116, '0);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_magnitude();
        t_sums();
        t_consts();
        t_accum_unsigned();
        t_refused();
        t_address();
        close_out();
    end
    initial begin
        #100_000;
        numErrors++;
        close_out();
    end
endmodule // test_dsp_add_abs_datapath
